/* File: pkg/fhvg_pkg.sv */
// Package: register map, field layout and constants of the flash high-voltage register gate
package fhvg_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [15:0] FHVG_ADDR_CTRL = 16'hff80;
    localparam logic [15:0] FHVG_ADDR_EBS_LO = 16'hff82;
    localparam logic [15:0] FHVG_ADDR_EBS_HI = 16'hff83;
    localparam logic [15:0] FHVG_ADDR_IRQ_STATUS = 16'hff84;
    localparam logic [15:0] FHVG_ADDR_IRQ_ENABLE = 16'hff85;
    localparam logic [15:0] FHVG_ADDR_IRQ_CLEAR = 16'hff86;
    localparam logic [15:0] FHVG_ADDR_FLASH_BASE = 16'h0000;

    // ****************************************
    // Reset and read-back values
    // ****************************************
    localparam logic [7:0] FHVG_CTRL_RESET = 8'h80;
    localparam logic [7:0] FHVG_EBS_RESET = 8'h00;
    localparam logic [7:0] FHVG_RESERVED_READ = 8'hff;
    localparam logic [7:0] FHVG_ERASED_BYTE = 8'hff;
    localparam logic [7:0] FHVG_ZERO_BYTE = 8'h00;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int FHVG_CTRL_HV_BIT = 7;
    localparam int FHVG_CTRL_ERASE_BIT = 1;
    localparam int FHVG_CTRL_PROG_BIT = 0;
    localparam logic [7:0] FHVG_CTRL_WMASK = 8'h0f;

    // ****************************************
    // Interrupt status fields
    // ****************************************
    localparam int FHVG_IRQ_HV_RISE = 0;
    localparam int FHVG_IRQ_HV_FALL = 1;
    localparam int FHVG_IRQ_WRITE_BLOCKED = 2;
    localparam int FHVG_IRQ_WIDTH = 3;

    // ****************************************
    // Programmer-mode flash geometry
    // ****************************************
    localparam int FHVG_FLASH_BYTES = 32768;
    localparam logic [16:0] FHVG_FLASH_TOP = 17'h1ffff;

endpackage : fhvg_pkg

/* File: hdl/fhvg_sync.sv */
// Module: two-stage level synchroniser
`timescale 1ns/1ps
module fhvg_sync
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);
    import fhvg_pkg::*;

    logic meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : fhvg_sync

/* File: hdl/fhvg_edge.sv */
// Module: rise and fall pulse detector on a synchronous level
`timescale 1ns/1ps
module fhvg_edge
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic level_in,
    output logic rise,
    output logic fall
);
    import fhvg_pkg::*;

    logic last_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            last_q <= 1'b0;
        end
        else
        begin
            last_q <= level_in;
        end
    end

    assign rise = level_in & ~last_q;
    assign fall = ~level_in & last_q;
endmodule : fhvg_edge

/* File: hdl/fhvg_gate.sv */
// Module: flash control register gate steered by the high-voltage detect flag
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

// Operation
// - High-voltage flag follows the supply pin threshold comparator, set above, cleared below.
// - While the flag is set, control and erase-block writes are accepted, except in its first cycle, where the supply-change clear wins.
// - Control and erase-block registers decode at 0xff80, 0xff82, 0xff83, gated by high voltage.
// - With high voltage the control register is read/write, reset value 0x80.
// - Without high voltage control address ignores writes and reads 0xff.
// - No flash read while the programming supply is changing.
// - Programmer-mode addresses beyond flash up to 0x1ffff always read 0xff.
module fhvg_gate
#(
    parameter int FLASH_BYTES = fhvg_pkg::FHVG_FLASH_BYTES
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic programming_supply_pin,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic programmer_mode,
    input wire logic [16:0] prog_addr,
    input wire logic prog_rd,
    input wire logic [7:0] flash_rdata,
    output logic [7:0] prog_rdata,
    output logic prog_read_blocked,
    output logic hv_present,
    output logic program_enable,
    output logic erase_enable,
    output logic [7:0] erase_block_lo,
    output logic [7:0] erase_block_hi,
    output logic irq
);
    import fhvg_pkg::*;

    // ****************************************
    // High-voltage detect
    // ****************************************
    logic hv_sync;
    logic hv_rise;
    logic hv_fall;

    // ****************************************
    // Register state and decode
    // ****************************************
    logic [7:0] ctrl_q;
    logic [7:0] ebs_lo_q;
    logic [7:0] ebs_hi_q;
    logic [FHVG_IRQ_WIDTH-1:0] irq_status_q;
    logic [FHVG_IRQ_WIDTH-1:0] irq_enable_q;
    logic [FHVG_IRQ_WIDTH-1:0] irq_event;
    logic [FHVG_IRQ_WIDTH-1:0] irq_clear;
    logic hv_changing;
    logic wr_ctrl;
    logic wr_ebs_lo;
    logic wr_ebs_hi;
    logic gated_hit;
    logic [7:0] rd_mux;
    logic [7:0] prog_mux;
    logic [FHVG_IRQ_WIDTH-1:0] irq_status_d;
    logic hit_ctrl;
    logic hit_ebs_lo;
    logic hit_ebs_hi;
    logic hit_irq_enable;
    logic hit_irq_clear;
    logic wr_blocked;

    fhvg_sync u_hv_sync
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in(programming_supply_pin),
        .sync_out(hv_sync)
    );

    fhvg_edge u_hv_edge
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .level_in(hv_sync),
        .rise(hv_rise),
        .fall(hv_fall)
    );

    // Supply transition window: flash reads are not trusted on the change edge
    assign hv_changing = hv_rise | hv_fall;

    // ****************************************
    // Address decode
    // ****************************************
    // Gating reads the synchronised flag only, never the raw pin
    assign hit_ctrl = (reg_addr == FHVG_ADDR_CTRL);
    assign hit_ebs_lo = (reg_addr == FHVG_ADDR_EBS_LO);
    assign hit_ebs_hi = (reg_addr == FHVG_ADDR_EBS_HI);
    assign hit_irq_enable = (reg_addr == FHVG_ADDR_IRQ_ENABLE);
    assign hit_irq_clear = (reg_addr == FHVG_ADDR_IRQ_CLEAR);
    assign gated_hit = hit_ctrl || hit_ebs_lo || hit_ebs_hi;
    assign wr_blocked = reg_wr && gated_hit && !hv_sync;
    assign wr_ctrl = reg_wr && hv_sync && hit_ctrl;
    assign wr_ebs_lo = reg_wr && hv_sync && hit_ebs_lo;
    assign wr_ebs_hi = reg_wr && hv_sync && hit_ebs_hi;

    // ****************************************
    // Control register
    // ****************************************
    // Program and erase bits drop on any supply change, so a stale set bit
    // cannot fire a pulse the moment high voltage reappears.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= FHVG_CTRL_RESET;
        end
        else if (hv_changing)
        begin
            ctrl_q <= FHVG_CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= FHVG_CTRL_RESET | (reg_wdata & FHVG_CTRL_WMASK);
        end
    end

    // ****************************************
    // Erase-block select registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ebs_lo_q <= FHVG_EBS_RESET;
        end
        else if (hv_changing)
        begin
            ebs_lo_q <= FHVG_EBS_RESET;
        end
        else if (wr_ebs_lo)
        begin
            ebs_lo_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ebs_hi_q <= FHVG_EBS_RESET;
        end
        else if (hv_changing)
        begin
            ebs_hi_q <= FHVG_EBS_RESET;
        end
        else if (wr_ebs_hi)
        begin
            ebs_hi_q <= reg_wdata;
        end
    end

    // ****************************************
    // Interrupt status, enable and clear
    // ****************************************
    assign irq_event[FHVG_IRQ_HV_RISE] = hv_rise;
    assign irq_event[FHVG_IRQ_HV_FALL] = hv_fall;
    assign irq_event[FHVG_IRQ_WRITE_BLOCKED] = wr_blocked;
    assign irq_clear = (reg_wr && hit_irq_clear) ? reg_wdata[FHVG_IRQ_WIDTH-1:0] : '0;

    // Status and interrupt output share one next value,
    // so they never disagree by a cycle
    always_comb
    begin
        irq_status_d = (irq_status_q & ~irq_clear) | irq_event;
    end

    // A set in the clearing cycle wins
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_status_q <= '0;
        end
        else
        begin
            irq_status_q <= irq_status_d;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_enable_q <= '0;
        end
        else if (reg_wr && hit_irq_enable)
        begin
            irq_enable_q <= reg_wdata[FHVG_IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_status_d & irq_enable_q);
        end
    end

    // ****************************************
    // Register read-back
    // ****************************************
    always_comb
    begin
        rd_mux = FHVG_ZERO_BYTE;
        unique case (reg_addr)
            FHVG_ADDR_CTRL: rd_mux = hv_sync ? ctrl_q : FHVG_RESERVED_READ;
            FHVG_ADDR_EBS_LO: rd_mux = hv_sync ? ebs_lo_q : FHVG_RESERVED_READ;
            FHVG_ADDR_EBS_HI: rd_mux = hv_sync ? ebs_hi_q : FHVG_RESERVED_READ;
            FHVG_ADDR_IRQ_STATUS: rd_mux = {{(8-FHVG_IRQ_WIDTH){1'b0}}, irq_status_q};
            FHVG_ADDR_IRQ_ENABLE: rd_mux = {{(8-FHVG_IRQ_WIDTH){1'b0}}, irq_enable_q};
            default: rd_mux = FHVG_ZERO_BYTE;
        endcase
    end

    // Read data stand in the cycle after the strobe only
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= FHVG_ZERO_BYTE;
        end
        else if (reg_rd)
        begin
            reg_rdata <= rd_mux;
        end
        else
        begin
            reg_rdata <= FHVG_ZERO_BYTE;
        end
    end

    // ****************************************
    // Programmer-mode read path
    // ****************************************
    // Addresses past the implemented array read erased data so that
    // a blank-check over the full address range matches.
    always_comb
    begin
        prog_mux = flash_rdata;
        if (prog_addr >= 17'(FLASH_BYTES))
        begin
            prog_mux = FHVG_ERASED_BYTE;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            prog_rdata <= FHVG_ERASED_BYTE;
        end
        else if (prog_rd && programmer_mode && !hv_changing)
        begin
            prog_rdata <= prog_mux;
        end
        else
        begin
            prog_rdata <= FHVG_ERASED_BYTE;
        end
    end

    // ****************************************
    // Programmer read block flag
    // ****************************************
    // A one-cycle pulse only: the programmer must retry the read itself
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            prog_read_blocked <= 1'b0;
        end
        else
        begin
            prog_read_blocked <= prog_rd && programmer_mode && hv_changing;
        end
    end

    // ****************************************
    // Registered outputs to the flash array
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            hv_present <= 1'b0;
        end
        else
        begin
            hv_present <= hv_sync;
        end
    end

    // Enables follow the flag directly so that they drop with it
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            program_enable <= 1'b0;
            erase_enable <= 1'b0;
        end
        else
        begin
            program_enable <= hv_sync && ctrl_q[FHVG_CTRL_PROG_BIT];
            erase_enable <= hv_sync && ctrl_q[FHVG_CTRL_ERASE_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            erase_block_lo <= FHVG_EBS_RESET;
            erase_block_hi <= FHVG_EBS_RESET;
        end
        else
        begin
            erase_block_lo <= ebs_lo_q;
            erase_block_hi <= ebs_hi_q;
        end
    end
endmodule : fhvg_gate

/* File: test/fhvg_properties.sv */
// Checker: port-level properties of the flash high-voltage register gate
`timescale 1ns/1ps
module fhvg_properties
import fhvg_pkg::*;
#(
    parameter int FLASH_BYTES = 32768
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic programming_supply_pin,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic programmer_mode,
    input wire logic [16:0] prog_addr,
    input wire logic prog_rd,
    input wire logic [7:0] prog_rdata,
    input wire logic prog_read_blocked,
    input wire logic hv_present,
    input wire logic program_enable,
    input wire logic erase_enable,
    input wire logic [7:0] erase_block_lo,
    input wire logic [7:0] erase_block_hi
);
    // ****************
    // Settle counter
    // ****************
    // History before reset release is not trusted for the flag delay
    logic [1:0] settle_q;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            settle_q <= 2'h0;
        else if (settle_q != 2'h3)
            settle_q <= settle_q + 2'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence ctrl_rd_s;
        reg_rd && reg_addr == FHVG_ADDR_CTRL;
    endsequence
    sequence prog_high_s;
        prog_rd && programmer_mode && prog_addr >= 17'(FLASH_BYTES);
    endsequence
    // ****************
    // Properties
    // ****************
    hv_track_a: assert property (settle_q == 2'h3 |-> hv_present == $past(programming_supply_pin, 3))
        else $error("hv flag does not follow the supply pin");
    ctrl_read_a: assert property (ctrl_rd_s |=> (hv_present ? reg_rdata[7:4] == 4'h8 : reg_rdata == 8'hff))
        else $error("control read-back wrong for supply state");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == FHVG_ZERO_BYTE)
        else $error("read data present without a read");
    enable_gate_a: assert property (program_enable || erase_enable |-> hv_present)
        else $error("program or erase enabled without high voltage");
    prog_rise_a: assert property ($rose(program_enable) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("program enable rose without a write");
    supply_clear_a: assert property ($changed(hv_present) |-> (!program_enable && !erase_enable)
        ##1 (erase_block_lo == FHVG_EBS_RESET && erase_block_hi == FHVG_EBS_RESET))
        else $error("state not cleared on supply change");
    prog_high_a: assert property (prog_high_s |=> prog_rdata == FHVG_ERASED_BYTE)
        else $error("read above flash area not erased value");
    prog_block_a: assert property (prog_read_blocked |-> prog_rdata == FHVG_ERASED_BYTE && $past(prog_rd))
        else $error("blocked read returned data");
endmodule : fhvg_properties

/* File: test/fhvg_supply_model.sv */
// Partner: programming supply and flash array seen by the gate
`timescale 1ns/1ps
module fhvg_supply_model
(
    input wire logic clk_sys,
    input wire logic [16:0] prog_addr,
    output logic programming_supply_pin,
    output logic [7:0] flash_rdata
);
    initial programming_supply_pin = 1'b0;
    // Pattern changes per address so a stuck read path shows
    assign flash_rdata = prog_addr[7:0] ^ 8'h5a;
    // Caller keeps the CPU off flash or in reset while the supply moves
    task automatic set_supply(input logic level);
        @(posedge clk_sys);
        programming_supply_pin <= level;
        repeat (4) @(posedge clk_sys);
    endtask : set_supply
endmodule : fhvg_supply_model

/* File: test/tb_top.sv */
// Testbench: register gating, interrupts and programmer reads
`timescale 1ns/1ps
module tb_top;
    import fhvg_pkg::*;
    localparam int FLASH_BYTES = 32768;
    localparam logic [7:0] EV_ALL = 8'((1 << FHVG_IRQ_HV_RISE) | (1 << FHVG_IRQ_HV_FALL) | (1 << FHVG_IRQ_WRITE_BLOCKED));
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic programmer_mode = 1'b0;
    logic [16:0] prog_addr = 17'h00000;
    logic prog_rd = 1'b0;
    logic programming_supply_pin;
    logic [7:0] flash_rdata, reg_rdata, prog_rdata, erase_block_lo, erase_block_hi;
    logic prog_read_blocked, hv_present, program_enable, erase_enable, irq;
    int n_errors = 0;
    int cmp_count = 0;
    always #10 clk_sys = ~clk_sys;
    fhvg_gate #(.FLASH_BYTES(FLASH_BYTES)) fhvg_gate_inst (.clk_sys, .resetn, .programming_supply_pin, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .programmer_mode, .prog_addr, .prog_rd, .flash_rdata, .prog_rdata,
        .prog_read_blocked, .hv_present, .program_enable, .erase_enable, .erase_block_lo, .erase_block_hi, .irq);
    fhvg_supply_model fhvg_supply_model_inst (.clk_sys, .prog_addr, .programming_supply_pin, .flash_rdata);
    // ****************
    // Access tasks
    // ****************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd
    task automatic prd(input logic [16:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        prog_rd <= 1'b1;
        prog_addr <= a;
        @(posedge clk_sys);
        prog_rd <= 1'b0;
        #1;
        chk(prog_rdata, e);
    endtask : prd
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // ****************
    // Tests
    // ****************
    initial
    begin
        repeat (2000) @(posedge clk_sys);
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(FHVG_ADDR_CTRL, FHVG_RESERVED_READ);
        rd(FHVG_ADDR_EBS_LO, FHVG_RESERVED_READ);
        wr(FHVG_ADDR_CTRL, 8'h03);
        fhvg_supply_model_inst.set_supply(1'b1);
        chk(8'(hv_present), 8'h01);
        chk(8'({erase_enable, program_enable}), 8'h00);
        rd(FHVG_ADDR_CTRL, FHVG_CTRL_RESET);
        wr(FHVG_ADDR_CTRL, 8'hff);
        rd(FHVG_ADDR_CTRL, 8'h8f);
        chk(8'({erase_enable, program_enable}), 8'h03);
        wr(FHVG_ADDR_EBS_LO, 8'ha5);
        wr(FHVG_ADDR_EBS_HI, 8'h3c);
        rd(FHVG_ADDR_EBS_LO, 8'ha5);
        rd(FHVG_ADDR_EBS_HI, 8'h3c);
        chk(erase_block_lo, 8'ha5);
        wr(FHVG_ADDR_CTRL, 8'h00);
        fhvg_supply_model_inst.set_supply(1'b0);
        rd(FHVG_ADDR_CTRL, FHVG_RESERVED_READ);
        chk(erase_block_lo, FHVG_EBS_RESET);
        chk(erase_block_hi, FHVG_EBS_RESET);
        rd(FHVG_ADDR_IRQ_STATUS, EV_ALL);
        chk(8'(irq), 8'h00);
        wr(FHVG_ADDR_IRQ_ENABLE, EV_ALL);
        rd(FHVG_ADDR_IRQ_ENABLE, EV_ALL);
        chk(8'(irq), 8'h01);
        wr(FHVG_ADDR_IRQ_CLEAR, 8'h01);
        rd(FHVG_ADDR_IRQ_STATUS, 8'h06);
        wr(FHVG_ADDR_IRQ_CLEAR, 8'h06);
        rd(FHVG_ADDR_IRQ_STATUS, 8'h00);
        chk(8'(irq), 8'h00);
        wr(FHVG_ADDR_IRQ_ENABLE, 8'h00);
        wr(FHVG_ADDR_CTRL, 8'h01);
        rd(FHVG_ADDR_IRQ_STATUS, 8'h04);
        chk(8'(irq), 8'h00);
        rd(16'hff90, 8'h00);
        @(posedge clk_sys);
        programmer_mode <= 1'b1;
        prd(17'h00000, 8'h5a);
        prd(17'(FLASH_BYTES - 1), 8'ha5);
        prd(17'(FLASH_BYTES), FHVG_ERASED_BYTE);
        prd(FHVG_FLASH_TOP, FHVG_ERASED_BYTE);
        fork
            fhvg_supply_model_inst.set_supply(1'b1);
            begin
                repeat (2) @(posedge clk_sys);
                prd(17'h00001, FHVG_ERASED_BYTE);
                chk(8'(prog_read_blocked), 8'h01);
            end
        join
        prd(17'h00001, 8'h5b);
        chk(8'(prog_read_blocked), 8'h00);
        wr(FHVG_ADDR_CTRL, 8'h02);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(8'(erase_enable), 8'h00);
        fhvg_supply_model_inst.set_supply(1'b0);
        resetn <= 1'b1;
        rd(FHVG_ADDR_CTRL, FHVG_RESERVED_READ);
        report_and_stop();
    end
endmodule : tb_top
bind fhvg_gate fhvg_properties #(.FLASH_BYTES(FLASH_BYTES)) fhvg_properties_inst (.clk_sys, .resetn,
    .programming_supply_pin, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .programmer_mode, .prog_addr, .prog_rd,
    .prog_rdata, .prog_read_blocked, .hv_present, .program_enable, .erase_enable, .erase_block_lo, .erase_block_hi);
